// [verification/ups_link_model.sv]
module ups_link_model (
  // clock
  input wire logic clock_i,
  // requests from the bench
  input wire logic ref_on_i,
  input wire logic rstn_req_i,
  input wire logic stp_req_i,
  // link pins
  output logic pll_reference_clock_o,
  output logic hw_reset_n_o,
  output logic stp_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // reset pin driven low from time zero, never left floating
  initial begin
    hw_reset_n_o = 1'b0;
    stp_o = 1'b0;
    pll_reference_clock_o = 1'b0;
  end
  // near 13 MHz; this half period never lands on a rising clock edge
  always #38.4 pll_reference_clock_o = ref_on_i ? ~pll_reference_clock_o : 1'b0;
  always @(negedge clock_i) begin
    hw_reset_n_o <= rstn_req_i;
    stp_o <= stp_req_i;
  end
endmodule : ups_link_model

// [verification/ups_startup_seq_chk.sv]
module ups_startup_seq_chk #(
  parameter int unsigned TIMEOUT = ups_pkg::REF_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pins
  input wire logic pll_reference_clock_i,
  input wire logic hw_reset_n_i,
  input wire logic stp_i,
  input wire logic core_supply_1v8_i,
  input wire logic por_done_i,
  // outputs
  input wire logic dir_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic interface_clock_output_o,
  input wire logic hs_clock_enable_o,
  input wire logic usb_full_enable_o,
  input wire logic reg_access_only_o,
  input wire logic regs_reset_o,
  input wire logic auto_resume_enable_o,
  input wire logic low_power_o
);
  logic [7:0] idle_cnt;
  logic ref_q;
  // cycles since the reference last moved, saturating
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt <= 8'h00;
      ref_q <= 1'b0;
    end else begin
      ref_q <= pll_reference_clock_i;
      if (ref_q != pll_reference_clock_i) idle_cnt <= 8'h00;
      else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_bus_idle: assert property (data_o == ups_pkg::ULPI_IDLE && data_oe_o == dir_o)
    else $error("data bus not idle");
  a_clock_pair: assert property (hs_clock_enable_o == interface_clock_output_o)
    else $error("clock enables differ");
  a_dir_before_lock: assert property ($rose(dir_o) |-> !interface_clock_output_o)
    else $error("dir rose while locked");
  a_dir_holds_stp: assert property ((stp_i && hw_reset_n_i && por_done_i &&
    core_supply_1v8_i)[*4] ##0 dir_o |=> dir_o)
    else $error("dir dropped with stp high");
  a_reset_holds: assert property (!hw_reset_n_i[*4] |=>
    !dir_o && !usb_full_enable_o && !reg_access_only_o)
    else $error("device active in reset");
  a_mode_excl: assert property (!(usb_full_enable_o && reg_access_only_o) &&
    !(dir_o && (usb_full_enable_o || reg_access_only_o)))
    else $error("operating modes overlap");
  a_regs_default: assert property (regs_reset_o |=> !auto_resume_enable_o)
    else $error("auto resume not at default");
  a_ref_loss: assert property (idle_cnt > TIMEOUT + 8 |-> !interface_clock_output_o)
    else $error("lock kept without reference");
  a_lp_wake: assert property (low_power_o && stp_i |-> ##[1:5] !low_power_o)
    else $error("stp did not wake device");
endmodule : ups_startup_seq_chk

bind ups_startup_seq ups_startup_seq_chk #(.TIMEOUT(TIMEOUT)) chk_u (.clock_i, .rst_i,
  .pll_reference_clock_i, .hw_reset_n_i, .stp_i, .core_supply_1v8_i, .por_done_i, .dir_o,
  .data_o, .data_oe_o, .interface_clock_output_o, .hs_clock_enable_o, .usb_full_enable_o,
  .reg_access_only_o, .regs_reset_o, .auto_resume_enable_o, .low_power_o);

// [verification/ups_startup_seq_test.sv]
module ups_startup_seq_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_done_i = 1'b0;
  logic core_supply_1v8_i = 1'b0;
  logic usb_supply_3v3_i = 1'b0;
  logic low_power_req_i = 1'b0;
  logic auto_resume_wr_i = 1'b0;
  logic auto_resume_wdata_i = 1'b0;
  logic ref_on = 1'b0;
  logic rstn_req = 1'b0;
  logic stp_req = 1'b0;
  logic ref_w, rstn_w, stp_w, dir_o, data_oe_o, if_clk, hs_clk, full_o, regs_only, regs_rst;
  logic auto_o, lp_o;
  logic [7:0] data_o;
  int errors = 0;
  int comparisons = 0;
  always #12.5 clock_i = ~clock_i;
  ups_link_model link_u (.clock_i(clock_i), .ref_on_i(ref_on), .rstn_req_i(rstn_req),
    .stp_req_i(stp_req), .pll_reference_clock_o(ref_w), .hw_reset_n_o(rstn_w), .stp_o(stp_w));
  // short lock count keeps the run brief
  ups_startup_seq #(.LOCK_EDGES(4), .TIMEOUT(16), .PULSE_CYCLES(40)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .pll_reference_clock_i(ref_w), .hw_reset_n_i(rstn_w),
    .stp_i(stp_w), .core_supply_1v8_i(core_supply_1v8_i), .usb_supply_3v3_i(usb_supply_3v3_i),
    .por_done_i(por_done_i), .low_power_req_i(low_power_req_i),
    .auto_resume_wr_i(auto_resume_wr_i), .auto_resume_wdata_i(auto_resume_wdata_i),
    .dir_o(dir_o), .data_o(data_o), .data_oe_o(data_oe_o), .interface_clock_output_o(if_clk),
    .hs_clock_enable_o(hs_clk), .usb_full_enable_o(full_o), .reg_access_only_o(regs_only),
    .regs_reset_o(regs_rst), .auto_resume_enable_o(auto_o), .low_power_o(lp_o));
  task chk(input string name, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task pulse(input logic d, input logic lp);
    auto_resume_wdata_i = d;
    auto_resume_wr_i = ~lp;
    low_power_req_i = lp;
    cyc(1);
    auto_resume_wr_i = 1'b0;
    low_power_req_i = 1'b0;
    cyc(3);
  endtask : pulse
  // reference and stp start together, as a waking link does
  task bring_up;
    ref_on = 1'b1;
    rstn_req = 1'b1;
    stp_req = 1'b1;
    cyc(5);
    chk("lock early", if_clk, 1'h0);
    for (int i = 0; i < 200 && if_clk !== 1'b1; i++) cyc(1);
    cyc(20);
    chk("hs clock", hs_clk, 1'h1);
    chk("dir held by stp", dir_o, 1'h1);
    chk("oe with dir", data_oe_o, 1'h1);
    chk("bus idle", data_o === ups_pkg::ULPI_IDLE, 1'h1);
    stp_req = 1'b0;
    for (int i = 0; i < 20 && dir_o !== 1'b0; i++) cyc(1);
    chk("dir released", dir_o, 1'h0);
    chk("oe released", data_oe_o, 1'h0);
  endtask : bring_up
  task s_held;
    por_done_i = 1'b1;
    core_supply_1v8_i = 1'b1;
    usb_supply_3v3_i = 1'b1;
    ref_on = 1'b1;
    cyc(60);
    chk("dir in reset", dir_o, 1'h0);
    chk("regs held", regs_rst, 1'h1);
    chk("clock in reset", if_clk, 1'h0);
    chk("auto resume", auto_o, 1'h0);
  endtask : s_held
  task s_late_ref;
    ref_on = 1'b0;
    rstn_req = 1'b1;
    cyc(60);
    chk("dir without ref", dir_o, 1'h1);
    chk("lock without ref", if_clk, 1'h0);
    bring_up();
    chk("full usb", full_o, 1'h1);
  endtask : s_late_ref
  task s_modes;
    pulse(1'b1, 1'b0);
    chk("auto resume set", auto_o, 1'h1);
    usb_supply_3v3_i = 1'b0;
    cyc(5);
    chk("register only", regs_only, 1'h1);
    chk("no full usb", full_o, 1'h0);
    usb_supply_3v3_i = 1'b1;
  endtask : s_modes
  // low power request: park, stop the reference, wake with stp
  task s_low_power;
    pulse(1'b0, 1'b1);
    chk("low power", lp_o, 1'h1);
    ref_on = 1'b0;
    cyc(40);
    chk("lock lost", if_clk, 1'h0);
    chk("still parked", lp_o, 1'h1);
    bring_up();
    chk("awake", lp_o, 1'h0);
  endtask : s_low_power
  task s_pulse;
    rstn_req = 1'b0;
    cyc(10);
    rstn_req = 1'b1;
    cyc(5);
    // any low level holds the device in reset, so registers clear as well
    chk("short pulse", auto_o, 1'h0);
    pulse(1'b1, 1'b0);
    chk("auto before pulse", auto_o, 1'h1);
    rstn_req = 1'b0;
    cyc(45);
    rstn_req = 1'b1;
    cyc(5);
    chk("long pulse", auto_o, 1'h0);
    bring_up();
  endtask : s_pulse
  task s_supply;
    pulse(1'b1, 1'b0);
    rstn_req = 1'b0;
    core_supply_1v8_i = 1'b0;
    cyc(6);
    chk("supply off", regs_rst, 1'h1);
    chk("auto cleared", auto_o, 1'h0);
    core_supply_1v8_i = 1'b1;
    cyc(10);
    bring_up();
  endtask : s_supply
  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    cyc(6);
    rst_i = 1'b0;
    s_held();
    s_late_ref();
    s_modes();
    s_low_power();
    s_pulse();
    s_supply();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    stop_test();
  end
endmodule : ups_startup_seq_test

// [verilog/ups_pkg.sv]
package ups_pkg;
  // 40 MHz system clock
  localparam int unsigned CLOCK_HZ = 40000000;
  localparam int unsigned CLOCK_PERIOD_NS = 25;
  // least low time on hw_reset_n that counts as a reset pulse
  localparam int unsigned RESET_PULSE_NS = 1000;
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // reference rising edges counted before lock is declared
  localparam int unsigned LOCK_EDGES = 64;
  // system cycles without a reference rising edge before lock is lost
  localparam int unsigned REF_TIMEOUT_CYCLES = 16;
  // ulpi idle value on the data bus
  localparam logic [7:0] ULPI_IDLE = 8'h00;
  // reset value of the auto resume control bit
  localparam logic AUTO_RESUME_RESET = 1'b0;
  // nominal pll figures
  localparam int unsigned REF_FREQ_MHZ = 13;
  localparam int unsigned HS_FREQ_MHZ = 480;
  localparam int unsigned IF_FREQ_MHZ = 60;

  typedef enum logic [2:0] {
    UPS_OFF = 3'h0,
    UPS_RESET = 3'h1,
    UPS_LOCKING = 3'h2,
    UPS_WAIT_STP = 3'h3,
    UPS_RUN = 3'h4,
    UPS_LOW_POWER = 3'h5
  } ups_state_t;
endpackage : ups_pkg

// [verilog/ups_pll_lock.sv]
// lock tracker: counts reference rising edges, loses lock when they stop
module ups_pll_lock #(
  parameter int unsigned LOCK_EDGES = ups_pkg::LOCK_EDGES,
  parameter int unsigned TIMEOUT = ups_pkg::REF_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic ref_rise_i,
  // status
  output logic locked_o,
  output logic ref_running_o
);
  // a timeout under two cycles would drop lock between ordinary edges
  if (LOCK_EDGES < 1 || TIMEOUT < 2) begin : g_bad_params
    $error("ups_pll_lock: bad parameters");
  end

  logic [$clog2(LOCK_EDGES+1)-1:0] edge_cnt;
  logic [$clog2(LOCK_EDGES+1)-1:0] next_edge_cnt;
  logic [$clog2(TIMEOUT+1)-1:0] idle_cnt;
  logic [$clog2(TIMEOUT+1)-1:0] next_idle_cnt;
  logic next_locked;
  logic next_running;

  always_comb begin
    next_edge_cnt = edge_cnt;
    next_idle_cnt = idle_cnt;
    next_locked = locked_o;
    next_running = ref_running_o;
    if (clear_i) begin
      next_edge_cnt = '0;
      next_idle_cnt = '0;
      next_locked = 1'b0;
      next_running = 1'b0;
    end else if (ref_rise_i) begin
      next_idle_cnt = '0;
      next_running = 1'b1;
      if (edge_cnt == LOCK_EDGES[$bits(edge_cnt)-1:0]) begin
        next_locked = 1'b1;
      end else begin
        next_edge_cnt = edge_cnt + 1'b1;
      end
    end else if (idle_cnt == TIMEOUT[$bits(idle_cnt)-1:0]) begin
      // reference gone: lock drops and the count restarts from scratch
      next_locked = 1'b0;
      next_running = 1'b0;
      next_edge_cnt = '0;
    end else begin
      next_idle_cnt = idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      edge_cnt <= '0;
      idle_cnt <= '0;
      locked_o <= 1'b0;
      ref_running_o <= 1'b0;
    end else begin
      edge_cnt <= next_edge_cnt;
      idle_cnt <= next_idle_cnt;
      locked_o <= next_locked;
      ref_running_o <= next_running;
    end
  end
endmodule : ups_pll_lock

// [verilog/ups_startup_seq.sv]
module ups_startup_seq #(
  parameter int unsigned LOCK_EDGES = ups_pkg::LOCK_EDGES,
  parameter int unsigned TIMEOUT = ups_pkg::REF_TIMEOUT_CYCLES,
  parameter int unsigned PULSE_CYCLES = ups_pkg::RESET_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pins from the link and the supplies
  input wire logic pll_reference_clock_i,
  input wire logic hw_reset_n_i,
  input wire logic stp_i,
  input wire logic core_supply_1v8_i,
  input wire logic usb_supply_3v3_i,
  input wire logic por_done_i,
  // low power request and auto resume write from the register block
  input wire logic low_power_req_i,
  input wire logic auto_resume_wr_i,
  input wire logic auto_resume_wdata_i,
  // ulpi side
  output logic dir_o,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // status
  output logic interface_clock_output_o,
  output logic hs_clock_enable_o,
  output logic usb_full_enable_o,
  output logic reg_access_only_o,
  output logic regs_reset_o,
  output logic auto_resume_enable_o,
  output logic low_power_o
);
  // the qualifier needs at least one counted cycle
  if (PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("ups_startup_seq: bad pulse length");
  end

  // two-flop synchronisers for every pin input
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {usb_supply_3v3_i, core_supply_1v8_i, por_done_i,
                 stp_i, hw_reset_n_i, pll_reference_clock_i};
      sync_b <= sync_a;
    end
  end
  logic ref_s;
  logic rstn_s;
  logic stp_s;
  logic por_s;
  logic v18_s;
  logic v33_s;
  assign {v33_s, v18_s, por_s, stp_s, rstn_s, ref_s} = sync_b;

  // rising edge detect on the reference; falling edges are ignored
  logic ref_d;
  logic ref_rise;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= ref_s;
    end
  end
  assign ref_rise = ref_s & ~ref_d;

  // reset pulse qualifier: a short glitch low does not arm pulse_reset, though hold still resets on any low
  logic [$clog2(PULSE_CYCLES+1)-1:0] low_cnt;
  logic [$clog2(PULSE_CYCLES+1)-1:0] next_low_cnt;
  logic armed;
  logic next_armed;
  logic pulse_reset;
  always_comb begin
    next_low_cnt = low_cnt;
    next_armed = armed;
    pulse_reset = 1'b0;
    if (!rstn_s) begin
      if (low_cnt == PULSE_CYCLES[$bits(low_cnt)-1:0]) begin
        next_armed = 1'b1;
      end else begin
        next_low_cnt = low_cnt + 1'b1;
      end
    end else begin
      next_low_cnt = '0;
      next_armed = 1'b0;
      pulse_reset = armed;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= '0;
      armed <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      armed <= next_armed;
    end
  end

  // device is held while the 1v8 core supply, por or reset pin is low
  logic hold;
  assign hold = ~v18_s | ~por_s | ~rstn_s;

  ups_pkg::ups_state_t state;
  ups_pkg::ups_state_t next_state;
  logic locked;
  logic ref_running;
  logic lock_clear;

  ups_pll_lock #(
    .LOCK_EDGES(LOCK_EDGES),
    .TIMEOUT(TIMEOUT)
  ) u_lock (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(lock_clear),
    .ref_rise_i(ref_rise),
    .locked_o(locked),
    .ref_running_o(ref_running)
  );

  // lock counting only starts from the first reference edge after release
  assign lock_clear = hold | (state == ups_pkg::UPS_RESET) |
                      (state == ups_pkg::UPS_LOW_POWER);

  logic next_dir;
  logic next_oe;
  logic next_regs_reset;
  logic next_auto_resume;
  logic next_ifclk;
  logic next_hsclk;
  logic next_full;
  logic next_regonly;
  logic next_lp;

  always_comb begin
    next_state = state;
    case (state)
      ups_pkg::UPS_OFF: begin
        if (v18_s) begin
          next_state = ups_pkg::UPS_RESET;
        end
      end
      ups_pkg::UPS_RESET: begin
        if (!hold) begin
          next_state = ups_pkg::UPS_LOCKING;
        end
      end
      ups_pkg::UPS_LOCKING: begin
        if (locked) begin
          next_state = ups_pkg::UPS_WAIT_STP;
        end
      end
      ups_pkg::UPS_WAIT_STP: begin
        if (!locked) begin
          next_state = ups_pkg::UPS_LOCKING;
        end else if (!stp_s) begin
          next_state = ups_pkg::UPS_RUN;
        end
      end
      ups_pkg::UPS_RUN: begin
        if (!locked) begin
          next_state = ups_pkg::UPS_LOCKING;
        end else if (low_power_req_i) begin
          next_state = ups_pkg::UPS_LOW_POWER;
        end
      end
      ups_pkg::UPS_LOW_POWER: begin
        // reference may be stopped here; stp brings the device back
        if (stp_s) begin
          next_state = ups_pkg::UPS_LOCKING;
        end
      end
      default: begin
        next_state = ups_pkg::UPS_OFF;
      end
    endcase
    if (!v18_s) begin
      next_state = ups_pkg::UPS_OFF;
    end else if (hold || pulse_reset) begin
      next_state = ups_pkg::UPS_RESET;
    end
  end

  always_comb begin
    next_dir = (next_state == ups_pkg::UPS_LOCKING) ||
               (next_state == ups_pkg::UPS_WAIT_STP);
    next_oe = next_dir;
    next_regs_reset = (next_state == ups_pkg::UPS_OFF) ||
                      (next_state == ups_pkg::UPS_RESET);
    next_auto_resume = auto_resume_enable_o;
    if (next_regs_reset) begin
      next_auto_resume = ups_pkg::AUTO_RESUME_RESET;
    end else if (auto_resume_wr_i) begin
      next_auto_resume = auto_resume_wdata_i;
    end
    // interface clock runs only from a locked pll; no phase tie to reference
    next_ifclk = locked && ref_running && !next_regs_reset;
    next_hsclk = next_ifclk;
    next_full = (next_state == ups_pkg::UPS_RUN) && v33_s;
    next_regonly = (next_state == ups_pkg::UPS_RUN) && !v33_s;
    next_lp = (next_state == ups_pkg::UPS_LOW_POWER);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ups_pkg::UPS_OFF;
      dir_o <= 1'b0;
      data_o <= ups_pkg::ULPI_IDLE;
      data_oe_o <= 1'b0;
      regs_reset_o <= 1'b1;
      auto_resume_enable_o <= ups_pkg::AUTO_RESUME_RESET;
      interface_clock_output_o <= 1'b0;
      hs_clock_enable_o <= 1'b0;
      usb_full_enable_o <= 1'b0;
      reg_access_only_o <= 1'b0;
      low_power_o <= 1'b0;
    end else begin
      state <= next_state;
      dir_o <= next_dir;
      data_o <= ups_pkg::ULPI_IDLE;
      data_oe_o <= next_oe;
      regs_reset_o <= next_regs_reset;
      auto_resume_enable_o <= next_auto_resume;
      interface_clock_output_o <= next_ifclk;
      hs_clock_enable_o <= next_hsclk;
      usb_full_enable_o <= next_full;
      reg_access_only_o <= next_regonly;
      low_power_o <= next_lp;
    end
  end
endmodule : ups_startup_seq
